// file: rtl/dmadx_pkg.sv
// Constants, descriptor layout and state types of the descriptor executor.
// Assumes a single 100 MHz clock and a word-wide memory port outside.
package dmadx_pkg;

    // Register offsets on the software port
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_PTR = 8'h04;
    localparam logic [7:0] REG_IDX = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam int CTRL_EN_BIT = 0;
    localparam int IDX_X_LSB = 0;
    localparam int IDX_Y_LSB = 8;

    // Descriptor word positions; next link sits at W_INNER + kind
    localparam logic [2:0] W_CTL = 3'h0;
    localparam logic [2:0] W_SRC = 3'h1;
    localparam logic [2:0] W_DST = 3'h2;
    localparam logic [2:0] W_INNER = 3'h3;
    localparam logic [2:0] W_OUTER = 3'h4;

    // Control word fields
    localparam int KIND_LSB = 0;
    localparam int IN_LSB = 2;
    localparam int OUT_LSB = 4;
    localparam int INTR_LSB = 6;
    localparam int WAIT_LSB = 8;
    localparam int OFF_BIT = 10;
    localparam int DSIZE_LSB = 12;
    localparam int SRC32_BIT = 14;
    localparam int DST32_BIT = 15;

    // Loop word fields: count, source step, destination step
    localparam int CNT_W = 8;
    localparam int STEP_W = 12;
    localparam int CNT_LSB = 0;
    localparam int SSTEP_LSB = 8;
    localparam int DSTEP_LSB = 20;

    // Descriptor kinds and access size codes
    localparam logic [1:0] KIND_SINGLE = 2'h0;
    localparam logic [1:0] KIND_1D = 2'h1;
    localparam logic [1:0] KIND_2D = 2'h2;
    localparam logic [1:0] SIZE_8 = 2'h0;
    localparam logic [1:0] SIZE_16 = 2'h1;
    localparam logic [1:0] SIZE_32 = 2'h2;

    // Timing, in clock cycles of the 100 MHz clock
    localparam logic [4:0] DEACT_SHORT_CYC = 5'h04;
    localparam logic [4:0] DEACT_LONG_CYC = 5'h10;
    localparam logic [1:0] OTRIG_CYC = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_FETCH = 3'h1,
        ST_READ = 3'h2,
        ST_WRITE = 3'h3,
        ST_WAIT = 3'h4
    } dmadx_state_t;

    // Memory request towards the bus master
    typedef struct packed {
        logic req;
        logic write;
        logic [1:0] size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } dmadx_mem_t;

    // Whole state of the executor
    typedef struct packed {
        dmadx_state_t state;
        logic enable;
        logic desc_valid;
        logic [31:0] ptr;
        logic [CNT_W-1:0] x;
        logic [CNT_W-1:0] y;
        logic [5:0][31:0] desc;
        logic [2:0] widx;
        logic [31:0] data;
        logic [4:0] wcnt;
        logic [1:0] wait_mode;
        logic [1:0] otr_cnt;
        logic otr;
        logic irq;
        dmadx_mem_t mem;
        logic [31:0] rdata;
    } dmadx_regs_t;

    localparam dmadx_regs_t REGS_RST = '0;

endpackage

// file: rtl/dmadx_exec.sv
// Descriptor executor of one DMA channel: fetch, element moves, loops,
// trigger handling, completion events and chaining.
// Assumes a memory port that answers a held request with a one-cycle
// ready, read data right-aligned and valid beside that ready.
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module dmadx_exec (
    // Clock and reset
    input wire logic I_CLOCK,
    input wire logic I_RSTN,
    // Software register port
    input wire logic [7:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [31:0] O_RDATA,
    // Memory master port
    output logic O_MEM_REQ,
    output logic O_MEM_WRITE,
    output logic [1:0] O_MEM_SIZE,
    output logic [31:0] O_MEM_ADDR,
    output logic [31:0] O_MEM_WDATA,
    input wire logic I_MEM_READY,
    input wire logic [31:0] I_MEM_RDATA,
    // Triggers and interrupt
    input wire logic I_TRIGGER,
    output logic O_OUT_TRIGGER,
    output logic O_INTERRUPT,
    output logic O_ENABLED
);

    dmadx_pkg::dmadx_regs_t r;
    dmadx_pkg::dmadx_regs_t next_r;

    // Element data mask: the configured element width
    function automatic logic [31:0] size_mask(input logic [1:0] sz);
        case (sz)
            dmadx_pkg::SIZE_8: size_mask = 32'h000000FF;
            dmadx_pkg::SIZE_16: size_mask = 32'h0000FFFF;
            default: size_mask = 32'hFFFFFFFF;
        endcase
    endfunction

    // Element address: base plus signed offsets scaled by access width
    function automatic logic [31:0] elem_addr(
        input logic [31:0] base,
        input logic [dmadx_pkg::CNT_W-1:0] xi,
        input logic [dmadx_pkg::CNT_W-1:0] yi,
        input logic [dmadx_pkg::STEP_W-1:0] sx,
        input logic [dmadx_pkg::STEP_W-1:0] sy,
        input logic [1:0] sh
    );
        logic signed [31:0] off;
        off = $signed({24'h000000, xi}) * $signed({{20{sx[11]}}, sx})
            + $signed({24'h000000, yi}) * $signed({{20{sy[11]}}, sy});
        elem_addr = base + 32'(off <<< sh);
    endfunction

    // Descriptor fields, decoded from the stored words
    logic [1:0] kind;
    logic [1:0] in_mode;
    logic [1:0] out_mode;
    logic [1:0] intr_sel;
    logic [1:0] wait_sel;
    logic off_after;
    logic [1:0] dsize;
    logic [1:0] src_sz;
    logic [1:0] dst_sz;
    logic [dmadx_pkg::CNT_W-1:0] cnt_x;
    logic [dmadx_pkg::CNT_W-1:0] cnt_y;
    logic [31:0] next_link;

    always_comb begin
        kind = r.desc[dmadx_pkg::W_CTL][dmadx_pkg::KIND_LSB +: 2];
        if (kind > dmadx_pkg::KIND_2D) begin
            kind = dmadx_pkg::KIND_SINGLE;
        end
        in_mode = r.desc[dmadx_pkg::W_CTL][dmadx_pkg::IN_LSB +: 2];
        out_mode = r.desc[dmadx_pkg::W_CTL][dmadx_pkg::OUT_LSB +: 2];
        intr_sel = r.desc[dmadx_pkg::W_CTL][dmadx_pkg::INTR_LSB +: 2];
        wait_sel = r.desc[dmadx_pkg::W_CTL][dmadx_pkg::WAIT_LSB +: 2];
        off_after = r.desc[dmadx_pkg::W_CTL][dmadx_pkg::OFF_BIT];
        dsize = r.desc[dmadx_pkg::W_CTL][dmadx_pkg::DSIZE_LSB +: 2];
        if (dsize > dmadx_pkg::SIZE_32) begin
            dsize = dmadx_pkg::SIZE_32;
        end
        // Access width is either the element width or a full word
        src_sz = r.desc[dmadx_pkg::W_CTL][dmadx_pkg::SRC32_BIT]
            ? dmadx_pkg::SIZE_32 : dsize;
        dst_sz = r.desc[dmadx_pkg::W_CTL][dmadx_pkg::DST32_BIT]
            ? dmadx_pkg::SIZE_32 : dsize;
        cnt_x = r.desc[dmadx_pkg::W_INNER][dmadx_pkg::CNT_LSB +: 8];
        cnt_y = r.desc[dmadx_pkg::W_OUTER][dmadx_pkg::CNT_LSB +: 8];
        next_link = r.desc[dmadx_pkg::W_INNER + {1'b0, kind}];
    end

    // Completion decode of the element now being written
    logic last_x;
    logic last_d;
    logic [3:0] ev;
    logic stop;
    logic [1:0] fetch_kind;

    always_comb begin
        last_x = (kind == dmadx_pkg::KIND_SINGLE) || (r.x == cnt_x);
        last_d = last_x &&
            ((kind != dmadx_pkg::KIND_2D) || (r.y == cnt_y));
        // Events by selector code: element, inner loop, descriptor, chain end
        ev[0] = 1'b1;
        ev[1] = last_x;
        ev[2] = last_d;
        ev[3] = last_d && (next_link == 32'h00000000);
        // How much work one trigger releases
        case (in_mode)
            2'h0: stop = 1'b1;
            2'h1: stop = last_x;
            2'h2: stop = last_d;
            default: stop = last_d && !(next_link != 32'h00000000
                && r.enable && !off_after);
        endcase
        // Kind of the descriptor being fetched, once its first word is in
        fetch_kind = (r.widx == dmadx_pkg::W_CTL)
            ? I_MEM_RDATA[dmadx_pkg::KIND_LSB +: 2] : kind;
        if (fetch_kind > dmadx_pkg::KIND_2D) begin
            fetch_kind = dmadx_pkg::KIND_SINGLE;
        end
    end

    // Next-state logic for the whole executor
    always_comb begin
        next_r = r;
        next_r.irq = 1'b0;
        next_r.rdata = 32'h00000000;
        if (r.otr_cnt != 2'h0) begin
            next_r.otr_cnt = r.otr_cnt - 2'h1;
        end

        case (r.state)
            dmadx_pkg::ST_IDLE: begin
                // A new trigger is only seen here, after deactivation
                if (r.enable && I_TRIGGER) begin
                    if (r.desc_valid) begin
                        next_r.state = dmadx_pkg::ST_READ;
                    end else begin
                        next_r.state = dmadx_pkg::ST_FETCH;
                        next_r.widx = dmadx_pkg::W_CTL;
                    end
                end
            end
            dmadx_pkg::ST_FETCH: begin
                // Words are read in order up to the next link, never written
                if (I_MEM_READY) begin
                    next_r.desc[r.widx] = I_MEM_RDATA;
                    if (r.widx == dmadx_pkg::W_INNER + {1'b0, fetch_kind}) begin
                        next_r.desc_valid = 1'b1;
                        next_r.state = dmadx_pkg::ST_READ;
                    end else begin
                        next_r.widx = r.widx + 3'h1;
                    end
                end
            end
            dmadx_pkg::ST_READ: begin
                if (I_MEM_READY) begin
                    // Upper source bits beyond the element width dropped
                    next_r.data = I_MEM_RDATA & size_mask(dsize);
                    next_r.state = dmadx_pkg::ST_WRITE;
                end
            end
            dmadx_pkg::ST_WRITE: begin
                if (I_MEM_READY) begin
                    if (ev[out_mode]) begin
                        next_r.otr_cnt = dmadx_pkg::OTRIG_CYC;
                    end
                    next_r.irq = ev[intr_sel];
                    // Index stepping: inner first, then outer
                    if (last_d) begin
                        next_r.x = '0;
                        next_r.y = '0;
                    end else if (last_x) begin
                        next_r.x = '0;
                        next_r.y = r.y + 8'h01;
                    end else begin
                        next_r.x = r.x + 8'h01;
                    end
                    if (last_d) begin
                        next_r.desc_valid = 1'b0;
                        // A zero link ends the chain and parks the channel
                        if (next_link == 32'h00000000) begin
                            next_r.enable = 1'b0;
                        end else begin
                            next_r.ptr = next_link;
                        end
                        if (off_after) begin
                            next_r.enable = 1'b0;
                        end
                    end
                    if (stop) begin
                        next_r.wait_mode = wait_sel;
                        next_r.wcnt = 5'h00;
                        next_r.state = dmadx_pkg::ST_WAIT;
                    end else if (last_d) begin
                        next_r.state = dmadx_pkg::ST_FETCH;
                        next_r.widx = dmadx_pkg::W_CTL;
                    end else begin
                        next_r.state = dmadx_pkg::ST_READ;
                    end
                end
            end
            dmadx_pkg::ST_WAIT: begin
                next_r.wcnt = r.wcnt + 5'h01;
                case (r.wait_mode)
                    2'h0: next_r.state = dmadx_pkg::ST_IDLE;
                    2'h1: begin
                        if (r.wcnt == dmadx_pkg::DEACT_SHORT_CYC - 5'h01) begin
                            next_r.state = dmadx_pkg::ST_IDLE;
                        end
                    end
                    2'h2: begin
                        if (r.wcnt == dmadx_pkg::DEACT_LONG_CYC - 5'h01) begin
                            next_r.state = dmadx_pkg::ST_IDLE;
                        end
                    end
                    default: begin
                        // Trigger must drop; idle then needs it high again
                        if (!I_TRIGGER) begin
                            next_r.state = dmadx_pkg::ST_IDLE;
                        end
                        next_r.wcnt = 5'h00;
                    end
                endcase
            end
            default: next_r.state = dmadx_pkg::ST_IDLE;
        endcase

        // Software writes come last so they win over a hardware clear
        if (I_WR) begin
            case (I_ADDR)
                dmadx_pkg::REG_CTRL: begin
                    next_r.enable = I_WDATA[dmadx_pkg::CTRL_EN_BIT];
                end
                dmadx_pkg::REG_PTR: begin
                    // Pointer and indices move only while idle, to keep a
                    // running transfer consistent
                    if (r.state == dmadx_pkg::ST_IDLE) begin
                        next_r.ptr = I_WDATA;
                        next_r.desc_valid = 1'b0;
                    end
                end
                dmadx_pkg::REG_IDX: begin
                    if (r.state == dmadx_pkg::ST_IDLE) begin
                        next_r.x = I_WDATA[dmadx_pkg::IDX_X_LSB +: 8];
                        next_r.y = I_WDATA[dmadx_pkg::IDX_Y_LSB +: 8];
                    end
                end
                default: ;
            endcase
        end

        // Register reads answer in the following cycle; unmapped read zero
        if (I_RD) begin
            case (I_ADDR)
                dmadx_pkg::REG_CTRL: next_r.rdata = {31'h0, r.enable};
                dmadx_pkg::REG_PTR: next_r.rdata = r.ptr;
                dmadx_pkg::REG_IDX: next_r.rdata = {16'h0000, r.y, r.x};
                dmadx_pkg::REG_STATUS: begin
                    next_r.rdata = {27'h0, r.desc_valid, r.enable, r.state};
                end
                default: next_r.rdata = 32'h00000000;
            endcase
        end

        next_r.otr = (next_r.otr_cnt != 2'h0);

        // Memory request follows the state being entered
        next_r.mem.req = 1'b0;
        next_r.mem.write = 1'b0;
        next_r.mem.size = dmadx_pkg::SIZE_32;
        next_r.mem.addr = 32'h00000000;
        next_r.mem.wdata = 32'h00000000;
        case (next_r.state)
            dmadx_pkg::ST_FETCH: begin
                next_r.mem.req = 1'b1;
                next_r.mem.addr = next_r.ptr + {27'h0, next_r.widx, 2'h0};
            end
            dmadx_pkg::ST_READ: begin
                next_r.mem.req = 1'b1;
                next_r.mem.size = src_sz;
                next_r.mem.addr = elem_addr(next_r.desc[dmadx_pkg::W_SRC],
                    next_r.x, next_r.y,
                    next_r.desc[dmadx_pkg::W_INNER][dmadx_pkg::SSTEP_LSB +: 12],
                    next_r.desc[dmadx_pkg::W_OUTER][dmadx_pkg::SSTEP_LSB +: 12],
                    src_sz);
            end
            dmadx_pkg::ST_WRITE: begin
                next_r.mem.req = 1'b1;
                next_r.mem.write = 1'b1;
                next_r.mem.size = dst_sz;
                next_r.mem.wdata = next_r.data;
                next_r.mem.addr = elem_addr(next_r.desc[dmadx_pkg::W_DST],
                    next_r.x, next_r.y,
                    next_r.desc[dmadx_pkg::W_INNER][dmadx_pkg::DSTEP_LSB +: 12],
                    next_r.desc[dmadx_pkg::W_OUTER][dmadx_pkg::DSTEP_LSB +: 12],
                    dst_sz);
            end
            default: ;
        endcase
    end

    // Whole state registered at once; reset is synchronous
    always_ff @(posedge I_CLOCK) begin
        if (!I_RSTN) begin
            r <= dmadx_pkg::REGS_RST;
        end else begin
            r <= next_r;
        end
    end

    // Outputs come straight from the state register
    assign O_RDATA = r.rdata;
    assign O_MEM_REQ = r.mem.req;
    assign O_MEM_WRITE = r.mem.write;
    assign O_MEM_SIZE = r.mem.size;
    assign O_MEM_ADDR = r.mem.addr;
    assign O_MEM_WDATA = r.mem.wdata;
    assign O_OUT_TRIGGER = r.otr;
    assign O_INTERRUPT = r.irq;
    assign O_ENABLED = r.enable;

endmodule

`default_nettype wire

// file: test/dmadx_exec_assertions.sv
// Concurrent checks on the top-level ports of the descriptor executor.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none

module dmadx_exec_checker (
    // Clock and reset
    input wire logic I_CLOCK,
    input wire logic I_RSTN,
    // Memory port
    input wire logic O_MEM_REQ,
    input wire logic O_MEM_WRITE,
    input wire logic [1:0] O_MEM_SIZE,
    input wire logic [31:0] O_MEM_ADDR,
    input wire logic [31:0] O_MEM_WDATA,
    input wire logic I_MEM_READY,
    // Events and state
    input wire logic O_OUT_TRIGGER,
    input wire logic O_INTERRUPT,
    input wire logic O_ENABLED
);
    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (!I_RSTN);

    // A request that the memory has not yet answered
    sequence s_stall;
        O_MEM_REQ && !I_MEM_READY;
    endsequence
    // First cycle of a destination write
    sequence s_new_write;
        O_MEM_REQ && O_MEM_WRITE && !$past(O_MEM_REQ && O_MEM_WRITE);
    endsequence

    property p_hold;
        s_stall |=> O_MEM_REQ && $stable(O_MEM_ADDR) && $stable(O_MEM_WRITE)
            && $stable(O_MEM_SIZE) && $stable(O_MEM_WDATA);
    endproperty
    a_hold: assert property (p_hold)
        else $error("memory request changed before ready");

    // Every write follows a completed source read
    property p_wr_after_rd;
        s_new_write |-> $past(O_MEM_REQ && !O_MEM_WRITE && I_MEM_READY);
    endproperty
    a_wr_after_rd: assert property (p_wr_after_rd)
        else $error("write not preceded by a completed read");

    property p_pad;
        O_MEM_REQ && O_MEM_WRITE |->
            (O_MEM_SIZE != dmadx_pkg::SIZE_8 || O_MEM_WDATA[31:8] == 24'h0)
            && (O_MEM_SIZE != dmadx_pkg::SIZE_16 || O_MEM_WDATA[31:16] == 16'h0);
    endproperty
    a_pad: assert property (p_pad)
        else $error("write data not zero padded");

    property p_otr_two;
        $rose(O_OUT_TRIGGER) |=> O_OUT_TRIGGER;
    endproperty
    a_otr_two: assert property (p_otr_two)
        else $error("output trigger shorter than two cycles");

    property p_otr_cause;
        $rose(O_OUT_TRIGGER) |-> $past(O_MEM_REQ && O_MEM_WRITE && I_MEM_READY);
    endproperty
    a_otr_cause: assert property (p_otr_cause)
        else $error("output trigger without completed element");

    property p_irq_cause;
        O_INTERRUPT |-> $past(O_MEM_REQ && O_MEM_WRITE && I_MEM_READY);
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("interrupt without completed element");

    property p_irq_pulse;
        O_INTERRUPT |=> !O_INTERRUPT;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse)
        else $error("interrupt longer than one cycle");

    // A disabled, quiet channel must not start a fetch
    property p_off_quiet;
        !O_ENABLED && !O_MEM_REQ |=> !O_MEM_REQ;
    endproperty
    a_off_quiet: assert property (p_off_quiet)
        else $error("memory request while channel disabled");
endmodule

bind dmadx_exec dmadx_exec_checker dmadx_exec_checker_i (
    .I_CLOCK(I_CLOCK),
    .I_RSTN(I_RSTN),
    .O_MEM_REQ(O_MEM_REQ),
    .O_MEM_WRITE(O_MEM_WRITE),
    .O_MEM_SIZE(O_MEM_SIZE),
    .O_MEM_ADDR(O_MEM_ADDR),
    .O_MEM_WDATA(O_MEM_WDATA),
    .I_MEM_READY(I_MEM_READY),
    .O_OUT_TRIGGER(O_OUT_TRIGGER),
    .O_INTERRUPT(O_INTERRUPT),
    .O_ENABLED(O_ENABLED)
);

`default_nettype wire

// file: test/dmadx_mem_model.sv
// Byte memory answering the executor's request/ready port.
// Assumes aligned accesses in a 256-byte window; latency set by i_lat.
`timescale 1ns/10ps
`default_nettype none

module dmadx_mem_model (
    // Clock and latency
    input wire logic i_clk,
    input wire logic [3:0] i_lat,
    // Request
    input wire logic i_req,
    input wire logic i_write,
    input wire logic [1:0] i_size,
    input wire logic [31:0] i_addr,
    input wire logic [31:0] i_wdata,
    // Answer
    output logic o_ready,
    output logic [31:0] o_rdata,
    output logic [7:0] o_bad_wr
);
    logic [7:0] mem [0:255];
    logic [3:0] cnt;
    logic [7:0] a;
    logic [31:0] mask;

    assign a = i_addr[7:0];
    assign mask = (i_size == 2'h0) ? 32'h000000FF :
        (i_size == 2'h1) ? 32'h0000FFFF : 32'hFFFFFFFF;

    initial begin
        o_ready = 1'b0;
        o_rdata = 32'h0;
        o_bad_wr = 8'h0;
        cnt = 4'h0;
    end

    // Read data toggles while no answer stands
    always @(posedge i_clk) begin
        o_ready <= 1'b0;
        o_rdata <= ~o_rdata;
        if (i_req && o_ready && i_write) begin
            mem[a] <= i_wdata[7:0];
            if (i_size != 2'h0) begin
                mem[a + 8'h1] <= i_wdata[15:8];
            end
            if (i_size == 2'h2) begin
                mem[a + 8'h2] <= i_wdata[23:16];
                mem[a + 8'h3] <= i_wdata[31:24];
            end
            if (a < 8'h80) begin
                o_bad_wr <= o_bad_wr + 8'h1;
            end
        end
        if (i_req && !o_ready) begin
            if (cnt == i_lat) begin
                o_ready <= 1'b1;
                cnt <= 4'h0;
                o_rdata <= {mem[a + 8'h3], mem[a + 8'h2], mem[a + 8'h1],
                    mem[a]} & mask;
            end else begin
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule

`default_nettype wire

// file: test/dmadx_exec_tb.sv
// Self-checking bench of the descriptor executor.
// Assumes descriptors at 0x40..0x7F and data at 0x80 and above.
`timescale 1ns/10ps
`default_nettype none

module dmadx_exec_tb;
    logic clk, rstn, wr, rd, req, we, ready, trig, otr, irq, en, otr_d;
    logic [7:0] addr, bad;
    logic [31:0] wdata, rdata, maddr, mwdata, mrdata;
    logic [1:0] size;
    logic [3:0] lat;
    int fail_count, tests_run, irq_n, otr_n, otr_hi, cyc, g1, g2;
    int irq_at [0:63];

    dmadx_exec dmadx_exec_i (.I_CLOCK(clk), .I_RSTN(rstn), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
        .O_MEM_REQ(req), .O_MEM_WRITE(we), .O_MEM_SIZE(size),
        .O_MEM_ADDR(maddr), .O_MEM_WDATA(mwdata), .I_MEM_READY(ready),
        .I_MEM_RDATA(mrdata), .I_TRIGGER(trig), .O_OUT_TRIGGER(otr),
        .O_INTERRUPT(irq), .O_ENABLED(en));
    dmadx_mem_model dmadx_mem_model_i (.i_clk(clk), .i_lat(lat),
        .i_req(req), .i_write(we), .i_size(size), .i_addr(maddr),
        .i_wdata(mwdata), .o_ready(ready), .o_rdata(mrdata),
        .o_bad_wr(bad));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Event counters and interrupt time stamps
    always @(posedge clk) begin
        cyc <= cyc + 1;
        otr_d <= otr;
        if (irq === 1'b1) begin
            irq_at[irq_n] <= cyc;
            irq_n <= irq_n + 1;
        end
        if (otr === 1'b1) otr_hi <= otr_hi + 1;
        if (otr === 1'b1 && otr_d !== 1'b1) otr_n <= otr_n + 1;
    end

    task summarize;
        if (fail_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the read edge
    task reg_rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask

    task wait_irq(input int n);
        for (int i = 0; i < 3000; i++) begin
            if (irq_n >= n) return;
            @(negedge clk);
        end
        fail_count++;
        $display("[FAIL] t=%0t irq=%h exp=%h", $time, irq_n, n);
        summarize();
    endtask

    task pw(input logic [7:0] a, input logic [31:0] d);
        for (int i = 0; i < 4; i++) begin
            dmadx_mem_model_i.mem[a + i[7:0]] = d[8*i +: 8];
        end
    endtask

    function automatic logic [31:0] gw(input logic [7:0] a);
        for (int i = 0; i < 4; i++) begin
            gw[8*i +: 8] = dmadx_mem_model_i.mem[a + i[7:0]];
        end
    endfunction

    task start(input logic [31:0] p);
        reg_wr(dmadx_pkg::REG_PTR, p);
        reg_wr(dmadx_pkg::REG_IDX, 32'h0);
        reg_wr(dmadx_pkg::REG_CTRL, 32'h1);
    endtask

    task pulse;
        @(posedge clk);
        trig <= 1'b1;
        repeat (2) @(posedge clk);
        trig <= 1'b0;
    endtask

    // Reset values, an unmapped place and a read-back
    task t_regs;
        reg_rd(dmadx_pkg::REG_CTRL, 32'h0);
        reg_rd(dmadx_pkg::REG_PTR, 32'h0);
        reg_rd(dmadx_pkg::REG_STATUS, 32'h0);
        reg_rd(8'h20, 32'h0);
        reg_wr(dmadx_pkg::REG_IDX, 32'h00000201);
        reg_rd(dmadx_pkg::REG_IDX, 32'h00000201);
    endtask

    // Lone 8-bit move between 32-bit places, end of chain
    task t_single;
        int i0, o0, h0;
        i0 = irq_n;
        o0 = otr_n;
        h0 = otr_hi;
        pw(8'h40, 32'h0000C0F0);
        pw(8'h44, 32'h80);
        pw(8'h48, 32'h90);
        pw(8'h4C, 32'h0);
        pw(8'h80, 32'hA5C31234);
        pw(8'h90, 32'hFFFFFFFF);
        start(32'h40);
        pulse();
        wait_irq(i0 + 1);
        repeat (5) @(posedge clk);
        chk(gw(8'h90), 32'h00000034);
        chk(otr_n - o0, 1);
        chk(otr_hi - h0, 2);
        chk(en, 1'b0);
        reg_rd(dmadx_pkg::REG_PTR, 32'h40);
    endtask

    // 16-bit inner loop of three, destination stepping downwards
    task t_1d;
        int i0, o0;
        i0 = irq_n;
        o0 = otr_n;
        pw(8'h40, 32'h00001045);
        pw(8'h44, 32'h80);
        pw(8'h48, 32'hA6);
        pw(8'h4C, 32'hFFF00102);
        pw(8'h50, 32'h0);
        pw(8'h80, 32'h22221111);
        pw(8'h84, 32'h00003333);
        pw(8'hA0, 32'h0);
        pw(8'hA4, 32'h0);
        start(32'h40);
        pulse();
        wait_irq(i0 + 1);
        repeat (40) @(posedge clk);
        chk(gw(8'hA4), 32'h11112222);
        chk(gw(8'hA0), 32'h33330000);
        chk(irq_n - i0, 1);
        chk(otr_n - o0, 3);
    endtask

    // 2x2 byte moves, one per trigger; g is one wait plus one move
    task t_2d(input logic [1:0] w, output int g);
        int i0, o0;
        i0 = irq_n;
        o0 = otr_n;
        pw(8'h40, {22'h0, w, 8'h12});
        pw(8'h44, 32'h80);
        pw(8'h48, 32'hB0);
        pw(8'h4C, 32'h00100101);
        pw(8'h50, 32'h00800401);
        pw(8'h54, 32'h0);
        pw(8'h80, 32'h44332211);
        pw(8'h84, 32'h88776655);
        pw(8'hB0, 32'h0);
        pw(8'hB8, 32'h0);
        start(32'h40);
        pulse();
        wait_irq(i0 + 1);
        repeat (40) @(posedge clk);
        chk(irq_n - i0, 1);
        @(posedge clk);
        trig <= 1'b1;
        wait_irq(i0 + 4);
        @(posedge clk);
        trig <= 1'b0;
        repeat (5) @(posedge clk);
        chk(gw(8'hB0), 32'h00002211);
        chk(gw(8'hB8), 32'h00006655);
        chk(otr_n - o0, 2);
        g = irq_at[i0 + 3] - irq_at[i0 + 2];
    endtask

    // Slow memory; auto-chained pair, then a held trigger must be refused
    task t_chain;
        int i0;
        i0 = irq_n;
        lat <= 4'h2;
        pw(8'h40, 32'h0000208C);
        pw(8'h44, 32'h80);
        pw(8'h48, 32'h94);
        pw(8'h4C, 32'h50);
        pw(8'h50, 32'h00002388);
        pw(8'h54, 32'h84);
        pw(8'h58, 32'h98);
        pw(8'h5C, 32'h60);
        pw(8'h60, 32'h00002480);
        pw(8'h64, 32'h88);
        pw(8'h68, 32'h9C);
        pw(8'h6C, 32'h40);
        pw(8'h80, 32'hAAAA0001);
        pw(8'h84, 32'hBBBB0002);
        pw(8'h88, 32'hCCCC0003);
        start(32'h40);
        @(posedge clk);
        trig <= 1'b1;
        wait_irq(i0 + 2);
        repeat (60) @(posedge clk);
        chk(irq_n - i0, 2);
        chk(gw(8'h98), 32'hBBBB0002);
        reg_rd(dmadx_pkg::REG_PTR, 32'h60);
        reg_rd(dmadx_pkg::REG_IDX, 32'h0);
        @(posedge clk);
        trig <= 1'b0;
        @(posedge clk);
        trig <= 1'b1;
        wait_irq(i0 + 3);
        @(posedge clk);
        trig <= 1'b0;
        repeat (5) @(posedge clk);
        chk(gw(8'h9C), 32'hCCCC0003);
        chk(en, 1'b0);
    endtask

    initial begin
        rstn = 1'b0;
        addr = 8'h0;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        trig = 1'b0;
        lat = 4'h0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        t_single();
        t_1d();
        t_2d(2'h1, g1);
        t_2d(2'h2, g2);
        chk(g2 - g1, 12);
        t_chain();
        chk(bad, 8'h0);
        summarize();
    end
endmodule

`default_nettype wire
